// ===== core/jfdp_flash_data_port.v
`timescale 1ns/10ps
`include "jfdp_defines.vh"
module jfdp_flash_data_port
(
  input  wire        sys_clk,
  input  wire        srst,
  // link side: toggle handshakes from the tap clock domain
  input  wire        link_wr_tgl,
  input  wire [7:0]  link_wr_byte,
  input  wire        link_rd_tgl,
  output wire [9:0]  flash_data_port,
  // unit side
  input  wire [7:0]  flash_access_control,
  input  wire        addr_load,
  input  wire [15:0] addr_load_val,
  output wire [15:0] flash_op_address,
  // flash array side
  output reg         fl_req,
  output reg  [1:0]  fl_op,
  output reg         fl_scratch,
  output reg  [15:0] fl_addr,
  output reg  [7:0]  fl_wdata,
  input  wire        fl_done,
  input  wire        fl_fail,
  input  wire [7:0]  fl_rdata
);

  localparam [1:0] OP_READ  = 2'h0;
  localparam [1:0] OP_PROG  = 2'h1;
  localparam [1:0] OP_ERASE = 2'h2;

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;

  wire [9:0] link_sync;
  wire       wr_tgl_s;
  wire       rd_tgl_s;
  wire [7:0] wr_byte_s;

  jfdp_sync #(.W(10)) u_sync
  (
    .sys_clk (sys_clk),
    .srst    (srst),
    .din     ({link_wr_tgl, link_rd_tgl, link_wr_byte}),
    .dout    (link_sync)
  );

  assign wr_tgl_s  = link_sync[9];
  assign rd_tgl_s  = link_sync[8];
  assign wr_byte_s = link_sync[7:0];

  reg        wr_tgl_d_r;
  reg        rd_tgl_d_r;
  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  reg [7:0]  byte_r;
  reg [7:0]  byte_nxt;
  reg        fail_r;
  reg        fail_nxt;
  reg        busy_r;
  reg        busy_nxt;
  reg        unread_r;
  reg        unread_nxt;
  reg [15:0] addr_r;
  reg [15:0] addr_nxt;
  reg        inc_pend_r;
  reg        inc_pend_nxt;
  reg        req_nxt;
  reg [1:0]  op_nxt;
  reg        scratch_nxt;
  reg [15:0] fl_addr_nxt;
  reg [7:0]  wdata_nxt;

  wire       wr_ev;
  wire       rd_ev;
  wire [2:0] write_action_select;
  wire [3:0] read_action_select;
  wire       scratchpad_select;
  wire       go_wr;
  wire       go_rd;

  assign wr_ev               = wr_tgl_s ^ wr_tgl_d_r;
  assign rd_ev               = rd_tgl_s ^ rd_tgl_d_r;
  assign write_action_select = flash_access_control[`JFDP_WR_ACT_MSB:`JFDP_WR_ACT_LSB];
  assign read_action_select  = flash_access_control[`JFDP_RD_ACT_MSB:`JFDP_RD_ACT_LSB];
  assign scratchpad_select   = flash_access_control[`JFDP_SCRATCH_BIT];

  // program decode, shared by the start test and the op code
  function is_prog;
    input [2:0] md;
    begin
      is_prog = (md == `JFDP_WR_PROG);
    end
  endfunction

  // erase only starts with the key byte
  function start_wr;
    input [2:0] md;
    input [7:0] d;
    begin
      start_wr = is_prog(md) || ((md == `JFDP_WR_ERASE) && (d == `JFDP_ERASE_KEY));
    end
  endfunction

  // single-read mode holds off until the last result was read out
  function start_rd;
    input [3:0] md;
    input       pending;
    begin
      start_rd = (md == `JFDP_RD_BLOCK) || ((md == `JFDP_RD_SINGLE) && !pending);
    end
  endfunction

  // a write wins over a read seen in the same cycle
  assign go_wr = wr_ev && !busy_r && start_wr(write_action_select, wr_byte_s);
  assign go_rd = rd_ev && !busy_r && !go_wr && start_rd(read_action_select, unread_r);

  always @*
  begin
    state_nxt    = state_r;
    byte_nxt     = byte_r;
    fail_nxt     = fail_r;
    busy_nxt     = busy_r;
    unread_nxt   = unread_r;
    addr_nxt     = addr_r;
    inc_pend_nxt = inc_pend_r;
    req_nxt      = 1'b0;
    op_nxt       = fl_op;
    scratch_nxt  = fl_scratch;
    fl_addr_nxt  = fl_addr;
    wdata_nxt    = fl_wdata;
    // writes while busy are dropped, data included
    if (wr_ev && !busy_r)
      byte_nxt = wr_byte_s;
    // any read consumes the last result, even while busy
    if (rd_ev)
      unread_nxt = 1'b0;
    // a load that meets a start is dropped, like one while busy
    if (addr_load && !busy_r && !(go_wr || go_rd))
      addr_nxt = addr_load_val;
    case (state_r)
      ST_IDLE:
      begin
        if (go_wr || go_rd)
        begin
          busy_nxt     = 1'b1;
          state_nxt    = ST_WAIT;
          req_nxt      = 1'b1;
          scratch_nxt  = scratchpad_select;
          fl_addr_nxt  = addr_r;
          wdata_nxt    = wr_byte_s;
          inc_pend_nxt = go_rd || is_prog(write_action_select);
          if (go_rd)
            op_nxt = OP_READ;
          else if (is_prog(write_action_select))
            op_nxt = OP_PROG;
          else
            op_nxt = OP_ERASE;
        end
      end
      ST_WAIT:
      begin
        if (fl_done)
        begin
          busy_nxt  = 1'b0;
          fail_nxt  = fl_fail;
          state_nxt = ST_IDLE;
          if (inc_pend_r)
            addr_nxt = addr_r + 16'h0001;
          // a new result beats a read event in the same cycle
          if (fl_op == OP_READ)
          begin
            byte_nxt   = fl_rdata;
            unread_nxt = 1'b1;
          end
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
        busy_nxt  = 1'b0;
      end
    endcase
  end

  // edge detect on the synchronised toggles
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      wr_tgl_d_r <= 1'b0;
      rd_tgl_d_r <= 1'b0;
    end
    else
    begin
      wr_tgl_d_r <= wr_tgl_s;
      rd_tgl_d_r <= rd_tgl_s;
    end
  end

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_r                  <= ST_IDLE;
      {byte_r, fail_r, busy_r} <= `JFDP_DAT_RST;
      unread_r                 <= 1'b0;
      addr_r                   <= `JFDP_ADR_RST;
      inc_pend_r               <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      byte_r     <= byte_nxt;
      fail_r     <= fail_nxt;
      busy_r     <= busy_nxt;
      unread_r   <= unread_nxt;
      addr_r     <= addr_nxt;
      inc_pend_r <= inc_pend_nxt;
    end
  end

  // request strobe and the qualifiers that stand until the next start
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      fl_req     <= 1'b0;
      fl_op      <= OP_READ;
      fl_scratch <= 1'b0;
      fl_addr    <= `JFDP_ADR_RST;
      fl_wdata   <= `JFDP_BYTE_RST;
    end
    else
    begin
      fl_req     <= req_nxt;
      fl_op      <= op_nxt;
      fl_scratch <= scratch_nxt;
      fl_addr    <= fl_addr_nxt;
      fl_wdata   <= wdata_nxt;
    end
  end

  assign flash_data_port  = {byte_r, fail_r, busy_r};
  assign flash_op_address = addr_r;

endmodule

// ===== pkg/jfdp_defines.vh
`ifndef JFDP_DEFINES_VH
`define JFDP_DEFINES_VH

// data port layout
`define JFDP_DAT_W          10
`define JFDP_BYTE_MSB       9
`define JFDP_BYTE_LSB       2
`define JFDP_FAIL_BIT       1
`define JFDP_BUSY_BIT       0
`define JFDP_DAT_RST        10'h000
`define JFDP_BYTE_RST       8'h00

// control register layout
`define JFDP_CTL_W          8
`define JFDP_CTL_RST        8'h00
`define JFDP_SCRATCH_BIT    7
`define JFDP_WR_ACT_MSB     6
`define JFDP_WR_ACT_LSB     4
`define JFDP_RD_ACT_MSB     3
`define JFDP_RD_ACT_LSB     0

// action codes
`define JFDP_WR_STORE       3'h0
`define JFDP_WR_PROG        3'h1
`define JFDP_WR_ERASE       3'h2
`define JFDP_RD_PLAIN       4'h0
`define JFDP_RD_BLOCK       4'h1
`define JFDP_RD_SINGLE      4'h2
`define JFDP_ERASE_KEY      8'ha5

// address
`define JFDP_ADR_W          16
`define JFDP_ADR_RST        16'h0000

`endif

// ===== core/jfdp_sync.v
`timescale 1ns/10ps
// two-stage synchroniser for pin-side levels
module jfdp_sync
#(
  parameter W = 1
)
(
  input  wire         sys_clk,
  input  wire         srst,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end
    else
    begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;

endmodule

// ===== verif/jfdp_monitor.sv
`timescale 1ns/10ps
module jfdp_monitor
(
  input logic        sys_clk,
  input logic        srst,
  input logic        fl_req,
  input logic [1:0]  fl_op,
  input logic [15:0] fl_addr,
  input logic [7:0]  fl_wdata,
  input logic        fl_done,
  input logic        fl_fail,
  input logic [9:0]  flash_data_port,
  input logic [15:0] flash_op_address
);
  wire b = flash_data_port[0];
  wire d = fl_done & b;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_go; fl_req |-> b && !$past(b); endproperty
  a_go: assert property (p_go) else $error("start");
  property p_end; d |=> !b; endproperty
  a_end: assert property (p_end) else $error("idle");
  property p_hold; b && !fl_done |=> b; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_fail; d |=> flash_data_port[1] == $past(fl_fail); endproperty
  a_fail: assert property (p_fail) else $error("fail");
  property p_inc; d && fl_op != 2'h2 |=> flash_op_address == $past(flash_op_address) + 16'h1; endproperty
  a_inc: assert property (p_inc) else $error("inc");
  property p_ers; d && fl_op == 2'h2 |=> $stable(flash_op_address); endproperty
  a_ers: assert property (p_ers) else $error("ers");
  property p_key; fl_req && fl_op == 2'h2 |-> fl_wdata == 8'ha5; endproperty
  a_key: assert property (p_key) else $error("key");
  property p_adr; fl_req |-> fl_addr == flash_op_address; endproperty
  a_adr: assert property (p_adr) else $error("adr");
  cover property (d && fl_fail);
  cover property (fl_req && fl_op == 2'h2);
  cover property (fl_req && fl_op == 2'h1);
endmodule
bind jfdp_flash_data_port jfdp_monitor u_mon(.*);

// ===== verif/jfdp_prog.sv
`timescale 1ns/10ps
module jfdp_prog
(
  input  logic [9:0] flash_data_port,
  output logic       link_wr_tgl = 1'b0,
  output logic       link_rd_tgl = 1'b0,
  output logic [7:0] link_wr_byte = 8'h00
);
  task wr(input logic [7:0] v);
    link_wr_byte = v;
    #640 link_wr_tgl = ~link_wr_tgl;
    #320 link_wr_byte = ~v;
    #320;
  endtask
  task rd;
    #640 link_rd_tgl = ~link_rd_tgl;
    #640;
  endtask
  task idle;
    repeat (99) if (flash_data_port[0] !== 1'b0) #320;
  endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/10ps
module tb;
  logic        sys_clk = 1'b0, srst = 1'b1, addr_load = 1'b0, fl_done = 1'b0, fl_fail = 1'b0;
  logic        link_wr_tgl, link_rd_tgl, fl_req, fl_scratch;
  logic [7:0]  flash_access_control = 8'h00, fl_rdata = 8'h00, link_wr_byte, fl_wdata;
  logic [15:0] addr_load_val = 16'h0000, flash_op_address, fl_addr;
  logic [9:0]  flash_data_port;
  logic [1:0]  fl_op;
  int          cnt, n0, n_req, n_errors, comparisons;
  jfdp_flash_data_port u_dut(.*);
  jfdp_prog u_prg(.*);
  initial forever #20 sys_clk = ~sys_clk;
  // flash array: slow answer, fails when fl_addr bit 8 is set
  always @(posedge sys_clk)
  begin
    n_req <= n_req + fl_req;
    cnt <= fl_req ? 40 : cnt - (cnt > 0);
    {fl_done, fl_fail, fl_rdata} <= #1 {cnt == 1, fl_addr[8], fl_addr[7:0] ^ 8'h3c};
  end
  task chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    n_errors += int'(got !== exp);
  endtask
  task set(input logic [7:0] c, input logic [15:0] a);
    @(posedge sys_clk);
    {flash_access_control, addr_load, addr_load_val} <= #1 {c, 1'b1, a};
    @(posedge sys_clk);
    addr_load <= #1 1'b0;
    #1 n0 = n_req;
  endtask
  task t_read;
    set(8'h01, 16'h00ff);
    u_prg.rd;
    u_prg.idle;
    chk({flash_op_address[5:0], flash_data_port}, 16'h030c);
    u_prg.rd;
    u_prg.idle;
    chk({flash_op_address[5:0], flash_data_port}, 16'h04f2);
  endtask
  task t_busy;
    set(8'h01, 16'h0010);
    u_prg.rd;
    u_prg.rd;
    u_prg.idle;
    chk(16'(n_req - n0), 16'h0001);
    set(8'h02, 16'h0011);
    u_prg.rd;
    u_prg.idle;
    u_prg.rd;
    u_prg.idle;
    chk({flash_op_address[7:0], 8'(n_req - n0)}, 16'h1201);
    chk({fl_op, fl_scratch}, 16'h0000);
  endtask
  task t_write;
    set(8'h90, 16'h0040);
    u_prg.wr(8'h5a);
    u_prg.idle;
    chk({fl_op, fl_scratch, fl_wdata}, 16'h035a);
    chk(flash_op_address, 16'h0041);
    set(8'h20, 16'h0041);
    u_prg.wr(8'h11);
    u_prg.wr(8'ha5);
    u_prg.idle;
    chk({flash_op_address[7:0], 8'(n_req - n0)}, 16'h4101);
    set(8'h00, 16'h0041);
    u_prg.wr(8'h3c);
    u_prg.rd;
    chk({6'(n_req - n0), flash_data_port}, 16'h00f0);
  endtask
  task summarize;
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    srst <= #1 1'b0;
    #50 chk(flash_data_port, 10'h000);
    t_read;
    t_busy;
    t_write;
    summarize;
  end
  initial
  begin
    #200000 n_errors++;
    summarize;
  end
endmodule
